// ===== hdl/area_fill_engine.sv
// Rectangle fill engine: sweeps a rectangle of field memory writing one colour.
// Assumes the field-memory side accepts a write when mem_ready is high, same clock.
`timescale 1ns/1ns
module area_fill_engine
(
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Fill request
	input wire logic start,
	input wire inset_cmd_pkg::fill_req_t req,
	output logic busy,
	// Field-memory write
	output logic mem_valid,
	output inset_cmd_pkg::mem_wr_t mem_wr,
	input wire logic mem_ready
);

	typedef enum logic {
		ENG_IDLE = 1'b0,
		ENG_RUN = 1'b1
	} eng_state_t;

	eng_state_t state_q;
	inset_cmd_pkg::fill_req_t req_q;
	logic [9:0] x_q;
	logic [9:0] y_q;
	logic last_x;
	logic last_y;
	logic on_ring;
	logic step;

	assign last_x = (x_q == req_q.pixels - 10'h001);
	assign last_y = (y_q == req_q.lines - 10'h001);
	assign on_ring = (x_q == 10'h000) || last_x || (y_q == 10'h000) || last_y;
	// A write in flight holds the sweep until the memory takes it
	assign step = (state_q == ENG_RUN) && (!mem_valid || mem_ready);

	////////////////////////////////////////////////////////////////////////////////
	// Sweep control
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q <= ENG_IDLE;
			req_q <= '0;
			x_q <= 10'h000;
			y_q <= 10'h000;
		end
		else if (state_q == ENG_IDLE)
		begin
			if (start)
			begin
				state_q <= ENG_RUN;
				req_q <= req;
				x_q <= 10'h000;
				y_q <= 10'h000;
			end
		end
		else if (step)
		begin
			if (last_x)
			begin
				x_q <= 10'h000;
				y_q <= y_q + 10'h001;
				if (last_y)
				begin
					state_q <= ENG_IDLE;
				end
			end
			else
			begin
				x_q <= x_q + 10'h001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Write port: interior points of a ring-only fill are skipped, not written
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			mem_valid <= 1'b0;
			mem_wr <= '0;
		end
		else if (step)
		begin
			mem_valid <= !req_q.ring_only || on_ring;
			mem_wr.line <= req_q.line + y_q;
			mem_wr.pixel <= req_q.pixel + x_q;
			mem_wr.colour <= req_q.colour;
		end
		else if (mem_ready)
		begin
			mem_valid <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			busy <= 1'b0;
		end
		else
		begin
			busy <= (state_q == ENG_RUN) ? !(step && last_x && last_y) || !mem_ready : start;
		end
	end

endmodule

// ===== hdl/inset_command_ctrl.sv
// Inset command interpreter: decodes the command byte, tracks live writing and display,
// places insets on the grid and drives the fill engine.
// Assumes all control inputs come from the serial control logic on the same clock.
//
// Behaviour
// - Frame commands paint inset border with frame colour a or b.
// - Background commands paint inset area with background colour, framed or frameless.
// - Commands start live writing into an inset, framed or frameless, or halt it.
// - Main-area command starts live writing outside insets, single combined device only.
// - Framed commands select bordered layout; frameless commands select borderless layout.
// - Each writer command other than main-area acts on the inset picked by its row and column indices.
// - Inset zero corner sits at the two origin offsets in the window.
// - Both origin offsets reset to zero.
// - Writer role: 0xc0 background, 0xa0 frame, 0x80 start live writing.
// - Writer role: 0x90 halts live writing, memory content kept.
// - Display role: 0x80 shows inset region, 0x90 stops showing it.
// - Low four bits hold two two-bit inset indices.
// - Start position changes move inset display without restart.
// - Role 0x01 selects inset writer, 0x05 selects main display.
// - Layout mode picks predefined layout; 0x0f picks expert layout.
// - No range checking or clamping of layout parameters.
`timescale 1ns/1ns
module inset_command_ctrl
(
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Command register write
	input wire logic cmd_write,
	input wire logic [7:0] inset_command_reg,
	output logic command_pending_flag,
	// Configuration
	input wire logic [7:0] device_role_reg,
	input wire logic [7:0] layout_mode_reg,
	input wire logic combined_device,
	input wire logic [9:0] origin_line_offset,
	input wire logic origin_line_offset_write,
	input wire logic [9:0] origin_pixel_offset,
	input wire logic origin_pixel_offset_write,
	input wire logic [9:0] horiz_start_pos,
	input wire logic [9:0] vert_start_pos,
	input wire logic [9:0] inset_pixel_count,
	input wire logic [9:0] inset_line_count,
	input wire logic [7:0] frame_colour_a,
	input wire logic [7:0] frame_colour_b,
	input wire logic [7:0] background_colour,
	// State
	output logic [15:0] live_write_mask,
	output logic framed_layout,
	output logic main_area_write,
	output logic inset_showing,
	output logic writer_role,
	output logic expert_layout,
	output inset_cmd_pkg::place_t live_place,
	output inset_cmd_pkg::place_t display_start,
	// Field-memory fill port
	output logic mem_valid,
	output inset_cmd_pkg::mem_wr_t mem_wr,
	input wire logic mem_ready
);

	typedef enum logic {
		CTL_IDLE = 1'b0,
		CTL_FILL = 1'b1
	} ctl_state_t;

	// Two frame widths: one on each side of a cell
	localparam logic [9:0] FRAME_W2 = inset_cmd_pkg::FRAME_W + inset_cmd_pkg::FRAME_W;

	////////////////////////////////////////////////////////////////////////////////
	// Decoding helpers

	function automatic inset_cmd_pkg::dop_t decode_cmd(input logic [7:0] cmd,
		input logic writer, input logic display);
		inset_cmd_pkg::dop_t d;
		d = inset_cmd_pkg::DOP_NONE;
		if (display)
		begin
			if (cmd == inset_cmd_pkg::CMD_SHOW_ON)
				d = inset_cmd_pkg::DOP_SHOW_ON;
			else if (cmd == inset_cmd_pkg::CMD_SHOW_OFF)
				d = inset_cmd_pkg::DOP_SHOW_OFF;
		end
		else if (writer)
		begin
			unique case (cmd[inset_cmd_pkg::OP_HI:inset_cmd_pkg::OP_LO])
				inset_cmd_pkg::OP_LIVE_FRAMED: d = inset_cmd_pkg::DOP_LIVE_FRAMED;
				inset_cmd_pkg::OP_HALT: d = inset_cmd_pkg::DOP_HALT;
				inset_cmd_pkg::OP_FRAME_A: d = inset_cmd_pkg::DOP_FRAME_A;
				inset_cmd_pkg::OP_FRAME_B: d = inset_cmd_pkg::DOP_FRAME_B;
				inset_cmd_pkg::OP_BG_FRAMED: d = inset_cmd_pkg::DOP_BG_FRAMED;
				inset_cmd_pkg::OP_BG_FRAMELESS: d = inset_cmd_pkg::DOP_BG_FRAMELESS;
				inset_cmd_pkg::OP_LIVE_FRAMELESS: d = inset_cmd_pkg::DOP_LIVE_FRAMELESS;
				inset_cmd_pkg::OP_MAIN_AREA: d = inset_cmd_pkg::DOP_MAIN_AREA;
				default: d = inset_cmd_pkg::DOP_NONE;
			endcase
		end
		return d;
	endfunction

	// Inset number from the two index fields: row above column
	function automatic logic [3:0] inset_number(input logic [7:0] cmd);
		return {cmd[inset_cmd_pkg::ROW_HI:inset_cmd_pkg::ROW_LO],
			cmd[inset_cmd_pkg::COLI_HI:inset_cmd_pkg::COLI_LO]};
	endfunction

	// Corner of an inset cell; no clamping, wrap on overflow is accepted
	function automatic logic [9:0] cell_corner(input logic [9:0] origin, input logic [1:0] idx,
		input logic [9:0] size, input logic framed);
		logic [9:0] pitch;
		pitch = framed ? size + FRAME_W2 : size;
		return origin + 10'(idx * pitch);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	ctl_state_t state_q;
	logic [7:0] cmd_q;
	logic [9:0] line_offs_q;
	logic [9:0] pix_offs_q;
	logic eng_busy;
	logic eng_start_q;
	inset_cmd_pkg::fill_req_t fill_req_q;
	inset_cmd_pkg::dop_t dop;
	logic accept;
	logic is_fill;
	logic role_writer;
	logic role_display;
	logic [9:0] size_pix;
	logic [9:0] size_lin;
	logic [9:0] corner_line;
	logic [9:0] corner_pixel;
	logic [3:0] target;
	logic cmd_framed;

	assign role_writer = (device_role_reg == inset_cmd_pkg::ROLE_WRITER);
	assign role_display = (device_role_reg == inset_cmd_pkg::ROLE_DISPLAY);
	assign dop = decode_cmd(cmd_q, role_writer, role_display);
	assign target = inset_number(cmd_q);
	assign is_fill = (dop == inset_cmd_pkg::DOP_FRAME_A) || (dop == inset_cmd_pkg::DOP_FRAME_B)
		|| (dop == inset_cmd_pkg::DOP_BG_FRAMED) || (dop == inset_cmd_pkg::DOP_BG_FRAMELESS);
	// Frameless variants are the only borderless ones
	assign cmd_framed = (dop != inset_cmd_pkg::DOP_BG_FRAMELESS)
		&& (dop != inset_cmd_pkg::DOP_LIVE_FRAMELESS);
	// Every command, fill or not, waits for an idle controller and a free engine
	assign accept = command_pending_flag && (state_q == CTL_IDLE) && !eng_busy && !eng_start_q;

	// Predefined layouts use fixed sizes, expert layout the programmed ones
	assign size_pix = expert_layout ? inset_pixel_count : inset_cmd_pkg::DEF_INSET_PIXELS;
	assign size_lin = expert_layout ? inset_line_count : inset_cmd_pkg::DEF_INSET_LINES;
	assign corner_line = cell_corner(line_offs_q, target[3:2], size_lin, cmd_framed);
	assign corner_pixel = cell_corner(pix_offs_q, target[1:0], size_pix, cmd_framed);

	////////////////////////////////////////////////////////////////////////////////
	// Command register and pending flag; a new write wins over the clear

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			cmd_q <= 8'h00;
			command_pending_flag <= 1'b0;
		end
		else if (cmd_write)
		begin
			cmd_q <= inset_command_reg;
			command_pending_flag <= 1'b1;
		end
		else if (accept)
		begin
			command_pending_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Origin offsets, start positions and mode registers

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			line_offs_q <= inset_cmd_pkg::OFFS_RESET;
			pix_offs_q <= inset_cmd_pkg::OFFS_RESET;
		end
		else
		begin
			if (origin_line_offset_write)
				line_offs_q <= origin_line_offset;
			if (origin_pixel_offset_write)
				pix_offs_q <= origin_pixel_offset;
		end
	end

	// Tracked every cycle so a live inset moves without any restart
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			display_start <= '0;
		end
		else
		begin
			display_start.line <= vert_start_pos;
			display_start.pixel <= horiz_start_pos;
		end
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			writer_role <= 1'b0;
			expert_layout <= 1'b0;
		end
		else
		begin
			writer_role <= role_writer;
			expert_layout <= (layout_mode_reg == inset_cmd_pkg::LAYOUT_EXPERT);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control state

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q <= CTL_IDLE;
		end
		else
		begin
			unique case (state_q)
				CTL_IDLE: if (accept && is_fill) state_q <= CTL_FILL;
				CTL_FILL: if (!eng_start_q && !eng_busy) state_q <= CTL_IDLE;
			endcase
		end
	end

	// Frame fills paint a one-pixel ring around the cell; backgrounds fill inside it
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			eng_start_q <= 1'b0;
			fill_req_q <= '0;
		end
		else
		begin
			eng_start_q <= accept && is_fill;
			if (accept && is_fill)
			begin
				unique case (dop)
					inset_cmd_pkg::DOP_FRAME_A, inset_cmd_pkg::DOP_FRAME_B:
					begin
						fill_req_q.line <= corner_line;
						fill_req_q.pixel <= corner_pixel;
						fill_req_q.lines <= size_lin + FRAME_W2;
						fill_req_q.pixels <= size_pix + FRAME_W2;
						fill_req_q.ring_only <= 1'b1;
						fill_req_q.colour <= (dop == inset_cmd_pkg::DOP_FRAME_A)
							? frame_colour_a : frame_colour_b;
					end
					inset_cmd_pkg::DOP_BG_FRAMED:
					begin
						fill_req_q.line <= corner_line + inset_cmd_pkg::FRAME_W;
						fill_req_q.pixel <= corner_pixel + inset_cmd_pkg::FRAME_W;
						fill_req_q.lines <= size_lin;
						fill_req_q.pixels <= size_pix;
						fill_req_q.ring_only <= 1'b0;
						fill_req_q.colour <= background_colour;
					end
					default:
					begin
						fill_req_q.line <= corner_line;
						fill_req_q.pixel <= corner_pixel;
						fill_req_q.lines <= size_lin;
						fill_req_q.pixels <= size_pix;
						fill_req_q.ring_only <= 1'b0;
						fill_req_q.colour <= background_colour;
					end
				endcase
			end
		end
	end

	// Layout style follows the last accepted writer command other than main-area
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			framed_layout <= 1'b1;
		else if (accept && role_writer && dop != inset_cmd_pkg::DOP_NONE
			&& dop != inset_cmd_pkg::DOP_MAIN_AREA)
			framed_layout <= cmd_framed;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Live writing per inset; a halt keeps the memory content untouched

	genvar gi;
	generate
		for (gi = 0; gi < inset_cmd_pkg::INSET_N; gi++)
		begin : g_live
			always_ff @(posedge clock or negedge resetn)
			begin
				if (!resetn)
					live_write_mask[gi] <= 1'b0;
				else if (accept && target == 4'(gi))
				begin
					if (dop == inset_cmd_pkg::DOP_LIVE_FRAMED || dop == inset_cmd_pkg::DOP_LIVE_FRAMELESS)
						live_write_mask[gi] <= 1'b1;
					else if (dop == inset_cmd_pkg::DOP_HALT)
						live_write_mask[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			live_place <= '0;
		else if (accept && (dop == inset_cmd_pkg::DOP_LIVE_FRAMED
			|| dop == inset_cmd_pkg::DOP_LIVE_FRAMELESS))
		begin
			live_place.line <= cmd_framed ? corner_line + inset_cmd_pkg::FRAME_W : corner_line;
			live_place.pixel <= cmd_framed ? corner_pixel + inset_cmd_pkg::FRAME_W : corner_pixel;
		end
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			main_area_write <= 1'b0;
		else if (accept && dop == inset_cmd_pkg::DOP_MAIN_AREA && combined_device)
			main_area_write <= 1'b1;
		else if (!role_writer)
			main_area_write <= 1'b0;
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			inset_showing <= 1'b0;
		else if (accept && dop == inset_cmd_pkg::DOP_SHOW_ON)
			inset_showing <= 1'b1;
		else if (accept && dop == inset_cmd_pkg::DOP_SHOW_OFF)
			inset_showing <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Fill engine

	area_fill_engine u_fill
	(
		.clock(clock),
		.resetn(resetn),
		.start(eng_start_q),
		.req(fill_req_q),
		.busy(eng_busy),
		.mem_valid(mem_valid),
		.mem_wr(mem_wr),
		.mem_ready(mem_ready)
	);

endmodule

// ===== include/inset_cmd_pkg.sv
// Shared constants, command encodings and carrier types of the inset command controller.
// Assumes one system clock; all users refer to names as inset_cmd_pkg::name.
package inset_cmd_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Widths
	localparam int unsigned POS_W = 10;
	localparam int unsigned COL_W = 8;
	localparam int unsigned CMD_W = 8;
	localparam int unsigned IDX_W = 2;
	localparam int unsigned INSET_N = 16;

	////////////////////////////////////////////////////////////////////////////////
	// Command byte layout: operation in the upper nibble, row and column indices below
	localparam int unsigned OP_HI = 7;
	localparam int unsigned OP_LO = 4;
	localparam int unsigned ROW_HI = 3;
	localparam int unsigned ROW_LO = 2;
	localparam int unsigned COLI_HI = 1;
	localparam int unsigned COLI_LO = 0;

	// Operation patterns in the inset-writing role
	localparam logic [3:0] OP_LIVE_FRAMED = 4'h8;
	localparam logic [3:0] OP_HALT = 4'h9;
	localparam logic [3:0] OP_FRAME_A = 4'ha;
	localparam logic [3:0] OP_FRAME_B = 4'hb;
	localparam logic [3:0] OP_BG_FRAMED = 4'hc;
	localparam logic [3:0] OP_BG_FRAMELESS = 4'hd;
	localparam logic [3:0] OP_LIVE_FRAMELESS = 4'he;
	localparam logic [3:0] OP_MAIN_AREA = 4'hf;

	// Whole command bytes in the displaying role
	localparam logic [7:0] CMD_SHOW_ON = 8'h80;
	localparam logic [7:0] CMD_SHOW_OFF = 8'h90;

	////////////////////////////////////////////////////////////////////////////////
	// Role and layout codes, reset values
	localparam logic [7:0] ROLE_WRITER = 8'h01;
	localparam logic [7:0] ROLE_DISPLAY = 8'h05;
	localparam logic [7:0] LAYOUT_EXPERT = 8'h0f;
	localparam logic [7:0] ROLE_RESET = 8'h00;
	localparam logic [7:0] LAYOUT_RESET = 8'h00;
	localparam logic [9:0] OFFS_RESET = 10'h000;
	localparam logic [9:0] FRAME_W = 10'h001;
	localparam logic [9:0] DEF_INSET_PIXELS = 10'h0b4;
	localparam logic [9:0] DEF_INSET_LINES = 10'h048;

	////////////////////////////////////////////////////////////////////////////////
	// Decoded operations
	typedef enum logic [3:0] {
		DOP_NONE = 4'b0000,
		DOP_FRAME_A = 4'b0001,
		DOP_FRAME_B = 4'b0010,
		DOP_BG_FRAMED = 4'b0011,
		DOP_BG_FRAMELESS = 4'b0100,
		DOP_LIVE_FRAMED = 4'b0101,
		DOP_LIVE_FRAMELESS = 4'b0110,
		DOP_HALT = 4'b0111,
		DOP_MAIN_AREA = 4'b1000,
		DOP_SHOW_ON = 4'b1001,
		DOP_SHOW_OFF = 4'b1010
	} dop_t;

	////////////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic [9:0] line;
		logic [9:0] pixel;
		logic [9:0] lines;
		logic [9:0] pixels;
		logic [7:0] colour;
		logic ring_only;
	} fill_req_t;

	typedef struct packed {
		logic [9:0] line;
		logic [9:0] pixel;
		logic [7:0] colour;
	} mem_wr_t;

	typedef struct packed {
		logic [9:0] line;
		logic [9:0] pixel;
	} place_t;

endpackage

// ===== tb/fill_mem_model.sv
// Field-memory write port model: takes fill writes, optionally stalling.
// Assumes the controller holds mem_valid and mem_wr until taken.
`timescale 1ns/1ns
module fill_mem_model
(
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Write port
	input wire logic mem_valid,
	input wire inset_cmd_pkg::mem_wr_t mem_wr,
	output logic mem_ready,
	// Bench control and tally
	input wire logic slow,
	input wire logic clr,
	output logic [15:0] wr_cnt,
	output inset_cmd_pkg::mem_wr_t first_wr,
	output logic [7:0] last_colour
);
	// A slow memory takes a write only every other cycle
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			mem_ready <= 1'b0;
		else
			mem_ready <= slow ? !mem_ready : 1'b1;
	end
	always_ff @(posedge clock)
	begin
		if (clr)
			wr_cnt <= 16'h0000;
		else if (mem_valid && mem_ready)
		begin
			if (wr_cnt == 16'h0000)
				first_wr <= mem_wr;
			last_colour <= mem_wr.colour;
			wr_cnt <= wr_cnt + 16'h0001;
		end
	end
endmodule

// ===== tb/inset_cmd_asserts.sv
// Checker for the inset command controller, bound to its top ports.
// Assumes one clock domain with asynchronous active-low reset.
`timescale 1ns/1ns
module inset_cmd_asserts
(
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Inputs
	input wire logic cmd_write,
	input wire logic [7:0] inset_command_reg,
	input wire logic [7:0] device_role_reg,
	input wire logic [7:0] layout_mode_reg,
	input wire logic [9:0] horiz_start_pos,
	input wire logic [9:0] vert_start_pos,
	input wire logic mem_ready,
	// Outputs
	input wire logic command_pending_flag,
	input wire logic [15:0] live_write_mask,
	input wire logic framed_layout,
	input wire logic inset_showing,
	input wire logic writer_role,
	input wire logic expert_layout,
	input wire inset_cmd_pkg::place_t display_start,
	input wire logic mem_valid,
	input wire inset_cmd_pkg::mem_wr_t mem_wr
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);
	////////////////////////////////////////////////////////////////////////////////
	// Only a write into a quiet controller has a fixed answer time
	logic [7:0] quiet_q;
	logic quiet;
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			quiet_q <= 8'h00;
		else if (mem_valid || command_pending_flag)
			quiet_q <= 8'h00;
		else if (quiet_q != 8'hff)
			quiet_q <= quiet_q + 8'h01;
	end
	assign quiet = cmd_write && !command_pending_flag && quiet_q >= 8'h08;
	////////////////////////////////////////////////////////////////////////////////
	property p_flag_set;
		cmd_write |=> command_pending_flag;
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("pending flag not set");
	property p_role;
		resetn |=> writer_role == ($past(device_role_reg) == 8'h01);
	endproperty
	a_role: assert property (p_role)
		else $error("writer role wrong");
	property p_expert;
		resetn |=> expert_layout == ($past(layout_mode_reg) == 8'h0f);
	endproperty
	a_expert: assert property (p_expert)
		else $error("expert layout wrong");
	property p_start;
		resetn |=> display_start == $past({vert_start_pos, horiz_start_pos});
	endproperty
	a_start: assert property (p_start)
		else $error("display start not followed");
	property p_hold;
		mem_valid && !mem_ready |=> mem_valid && $stable(mem_wr);
	endproperty
	a_hold: assert property (p_hold)
		else $error("fill write dropped");
	property p_live;
		quiet && writer_role && inset_command_reg[7:4] == 4'h8
			|-> ##3 live_write_mask[$past(inset_command_reg[3:0], 3)] && framed_layout;
	endproperty
	a_live: assert property (p_live)
		else $error("live write not started");
	property p_halt;
		quiet && writer_role && inset_command_reg[7:4] == 4'h9
			|-> ##3 !live_write_mask[$past(inset_command_reg[3:0], 3)];
	endproperty
	a_halt: assert property (p_halt)
		else $error("live write not halted");
	property p_frameless;
		quiet && writer_role && inset_command_reg[7:4] == 4'he
			|-> ##3 live_write_mask[$past(inset_command_reg[3:0], 3)] && !framed_layout;
	endproperty
	a_frameless: assert property (p_frameless)
		else $error("frameless live write wrong");
	property p_ignored;
		quiet && !inset_command_reg[7] |=> $stable(live_write_mask) [*3];
	endproperty
	a_ignored: assert property (p_ignored)
		else $error("undefined command changed state");
	property p_show;
		quiet && !writer_role && device_role_reg == 8'h05
			&& (inset_command_reg == 8'h80 || inset_command_reg == 8'h90)
			|-> ##3 inset_showing == !$past(inset_command_reg[4], 3);
	endproperty
	a_show: assert property (p_show)
		else $error("inset display state wrong");
	c_fill: cover property (mem_valid && mem_ready);
	c_show: cover property (inset_showing);
	c_frameless: cover property (!framed_layout && live_write_mask != 16'h0000);
endmodule

// ===== tb/pip_command_controller_bench.sv
// Self-checking bench of the inset command controller with a field-memory model.
// Assumes expert layout of 3 pixels by 2 lines so that each fill stays short.
`timescale 1ns/1ns
module pip_command_controller_bench;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic cmd_write = 1'b0;
	logic [7:0] inset_command_reg = 8'h00;
	logic [7:0] device_role_reg = 8'h01;
	logic [7:0] layout_mode_reg = 8'h0f;
	logic combined_device = 1'b0;
	logic [9:0] origin_line_offset = 10'h000;
	logic origin_line_offset_write = 1'b0;
	logic [9:0] origin_pixel_offset = 10'h000;
	logic origin_pixel_offset_write = 1'b0;
	logic [9:0] horiz_start_pos = 10'h000;
	logic [9:0] vert_start_pos = 10'h000;
	logic [9:0] inset_pixel_count = 10'h003;
	logic [9:0] inset_line_count = 10'h002;
	logic [7:0] frame_colour_a = 8'h11;
	logic [7:0] frame_colour_b = 8'h22;
	logic [7:0] background_colour = 8'h33;
	logic command_pending_flag, framed_layout, main_area_write, inset_showing;
	logic writer_role, expert_layout, mem_valid, mem_ready;
	logic [15:0] live_write_mask, wr_cnt;
	logic [7:0] last_colour;
	logic slow = 1'b0;
	logic clr = 1'b0;
	inset_cmd_pkg::place_t live_place, display_start;
	inset_cmd_pkg::mem_wr_t mem_wr, first_wr;
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	inset_command_ctrl dut_u (.clock, .resetn, .cmd_write, .inset_command_reg,
		.command_pending_flag, .device_role_reg, .layout_mode_reg, .combined_device,
		.origin_line_offset, .origin_line_offset_write, .origin_pixel_offset,
		.origin_pixel_offset_write, .horiz_start_pos, .vert_start_pos, .inset_pixel_count,
		.inset_line_count, .frame_colour_a, .frame_colour_b, .background_colour,
		.live_write_mask, .framed_layout, .main_area_write, .inset_showing, .writer_role,
		.expert_layout, .live_place, .display_start, .mem_valid, .mem_wr, .mem_ready);
	fill_mem_model mem_u (.clock, .resetn, .mem_valid, .mem_wr, .mem_ready, .slow, .clr,
		.wr_cnt, .first_wr, .last_colour);
	always #4 clock = ~clock;
	////////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		if (error_cnt == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			error_cnt++;
			report_and_stop();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// Host write, then poll the flag and let any fill drain
	task automatic send(input logic [7:0] b);
		int quiet;
		@(posedge clock);
		cmd_write <= 1'b1;
		inset_command_reg <= b;
		@(posedge clock);
		cmd_write <= 1'b0;
		#1;
		check("pending", command_pending_flag, 1);
		quiet = 0;
		while (quiet < 10)
		begin
			tick(1);
			quiet = (command_pending_flag === 1'b0 && mem_valid === 1'b0) ? quiet + 1 : 0;
		end
	endtask
	task automatic fill(input logic [7:0] b, input logic [15:0] n, input logic [9:0] l,
		input logic [9:0] p, input logic [7:0] c);
		@(posedge clock);
		clr <= 1'b1;
		@(posedge clock);
		clr <= 1'b0;
		send(b);
		check("writes", wr_cnt, n);
		check("first", {first_wr.line, first_wr.pixel}, {l, p});
		check("colour", last_colour, c);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		logic [3:0] nib;
		repeat (16) @(posedge clock);
		resetn <= 1'b1;
		tick(1);
		check("framed", framed_layout, 1);
		check("mask", live_write_mask, 16'h0000);
		check("role", writer_role, 1);
		check("expert", expert_layout, 1);
		fill(8'hc0, 16'd6, 10'h001, 10'h001, 8'h33);
		slow <= 1'b1;
		fill(8'ha0, 16'd14, 10'h000, 10'h000, 8'h11);
		fill(8'hb0, 16'd14, 10'h000, 10'h000, 8'h22);
		// New group origin, then row 1 column 1 and row 1 column 2
		@(posedge clock);
		origin_line_offset <= 10'h2b8;
		origin_pixel_offset <= 10'h010;
		origin_line_offset_write <= 1'b1;
		origin_pixel_offset_write <= 1'b1;
		@(posedge clock);
		origin_line_offset_write <= 1'b0;
		origin_pixel_offset_write <= 1'b0;
		fill(8'hc5, 16'd6, 10'h2bd, 10'h016, 8'h33);
		fill(8'ha5, 16'd14, 10'h2bc, 10'h015, 8'h11);
		fill(8'hd6, 16'd6, 10'h2ba, 10'h016, 8'h33);
		check("framed", framed_layout, 0);
		slow <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			nib = {1'b0, i[1], 1'b0, i[0]};
			send({4'h8, nib});
			check("live", live_write_mask, 16'h0001 << nib);
			check("framed", framed_layout, 1);
			send({4'h9, nib});
			check("halt", live_write_mask, 16'h0000);
		end
		send(8'he6);
		check("live", live_write_mask, 16'h0040);
		check("place", live_place, {10'h2ba, 10'h016});
		check("framed", framed_layout, 0);
		send(8'h30);
		check("ignored", live_write_mask, 16'h0040);
		send(8'hf0);
		check("main", main_area_write, 0);
		@(posedge clock);
		combined_device <= 1'b1;
		send(8'hf0);
		check("main", main_area_write, 1);
		@(posedge clock);
		layout_mode_reg <= 8'h02;
		device_role_reg <= 8'h05;
		tick(2);
		check("expert", expert_layout, 0);
		check("role", writer_role, 0);
		send(8'h80);
		check("show", inset_showing, 1);
		send(8'h90);
		check("show", inset_showing, 0);
		@(posedge clock);
		horiz_start_pos <= 10'h103;
		vert_start_pos <= 10'h202;
		tick(2);
		check("start", display_start, {10'h202, 10'h103});
		report_and_stop();
	end
endmodule
bind inset_command_ctrl inset_cmd_asserts chk_u (.clock, .resetn, .cmd_write,
	.inset_command_reg, .device_role_reg, .layout_mode_reg, .horiz_start_pos,
	.vert_start_pos, .mem_ready, .command_pending_flag, .live_write_mask, .framed_layout,
	.inset_showing, .writer_role, .expert_layout, .display_start, .mem_valid, .mem_wr);
